// ==== core/ift_regs.svh ====
// Named constants of the interval flag timer: times, encodings, reset values.
// Assumes inclusion by its bare name from the package and the design modules.
`ifndef IFT_REGS_SVH
`define IFT_REGS_SVH

// ----------------------------------------------------------------------------
// Clock and interval times
// ----------------------------------------------------------------------------
`define IFT_CLK_PERIOD_NS      40
`define IFT_INTERVAL_100MS_NS  100000000
`define IFT_INTERVAL_50MS_NS   50000000
`define IFT_INTERVAL_20MS_NS   20000000
`define IFT_INTERVAL_10MS_NS   10000000
`define IFT_PHASE_STEP_NS      40000

// ----------------------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------------------
`define IFT_SEL_W              2
`define IFT_SEL_100MS          2'h0
`define IFT_SEL_50MS           2'h1
`define IFT_SEL_20MS           2'h2
`define IFT_SEL_10MS           2'h3
`define IFT_SEL_RESET          2'h0
`define IFT_CARRY_W            4
`define IFT_CARRY_RESET        4'h0
`define IFT_CARRY_ONE          4'h1
`define IFT_ADDR_W             14
`define IFT_RESET_VECTOR       14'h0000
`define IFT_NUM_PULSES         4

`endif

// ==== core/ift_pkg.sv ====
// Types shared by the interval flag timer modules.
// Assumes the constants header is on the include path.
`include "ift_regs.svh"

package ift_pkg;

    // ------------------------------------------------------------------------
    // Interval selection and carriers
    // ------------------------------------------------------------------------
    typedef enum logic [`IFT_SEL_W-1:0] {
        IFT_SEL_100MS = `IFT_SEL_100MS,
        IFT_SEL_50MS  = `IFT_SEL_50MS,
        IFT_SEL_20MS  = `IFT_SEL_20MS,
        IFT_SEL_10MS  = `IFT_SEL_10MS
    } ift_sel_t;

    typedef struct packed {
        logic     wr;
        ift_sel_t data;
    } ift_sel_wr_t;

    typedef struct packed {
        logic                    en;
        logic [`IFT_CARRY_W-1:0] count;
    } ift_delay_cfg_t;

    typedef enum logic [2:0] {
        IFT_ST_IDLE = 3'b001,
        IFT_ST_WAIT = 3'b010,
        IFT_ST_DONE = 3'b100
    } ift_state_t;

endpackage : ift_pkg

// ==== core/ift_pulse_div.sv ====
// Free-running divider that makes one periodic square pulse from the clock.
// Assumes a synchronous active-low reset and a run level from the top.
`timescale 1ns/1ps
`default_nettype none

module ift_pulse_div #(
    parameter int PERIOD = 2500000,
    parameter int PHASE  = 0
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic run,
    output var  logic pulse
);
    localparam int CW = $clog2(PERIOD);
    localparam logic [CW-1:0] LAST  = CW'(PERIOD - 1);
    localparam logic [CW-1:0] HALF  = CW'(PERIOD / 2);
    localparam logic [CW-1:0] START = CW'(PHASE);

    logic [CW-1:0] cnt_reg;

    // Refuse periods that cannot make a square wave, and phases past a period.
    if (PERIOD < 2 || PHASE < 0 || PHASE >= PERIOD) begin : g_bad
        $error("ift_pulse_div: PERIOD or PHASE out of range");
    end

    // The counter never listens to the selection, so no pulse is ever realigned.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg <= START;
        end else if (run) begin
            cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
        end
    end

    // High in the first half of each period.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pulse <= 1'b0;
        end else begin
            pulse <= (cnt_reg < HALF);
        end
    end

    chk_div_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        (run && cnt_reg == LAST) |=> cnt_reg == '0)
        else $error("divider did not wrap at end of period");

endmodule : ift_pulse_div

`default_nettype wire

// ==== core/ift_edge_sel.sv ====
// Picks the selected interval pulse and turns its rising edge into a strobe.
// Assumes the pulses are registered in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "ift_regs.svh"

module ift_edge_sel
    import ift_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic [`IFT_NUM_PULSES-1:0] pulses,
    input  wire ift_pkg::ift_sel_t          sel,
    output var  logic                       rise
);
    logic sel_pulse;
    logic prev_reg;

    // The previous sample is of the selected pulse itself, so a selection
    // switch looks like an edge of the new pulse: low to high sets, high to
    // low does nothing.
    assign sel_pulse = pulses[sel];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev_reg <= 1'b1;
        end else begin
            prev_reg <= sel_pulse;
        end
    end

    // One-cycle strobe on a low to high step of the selected pulse.
    assign rise = sel_pulse & ~prev_reg;

endmodule : ift_edge_sel

`default_nettype wire

// ==== core/ift_timer.sv ====
// Interval flag timer with backup reset: four free pulses, a read-to-clear
// flag and a backup reset lined up with the selected pulse.
// Assumes every input is synchronous to CLK and read strobes last one cycle.
//
// Summary of operation
// - Four dividers make 10, 20, 50 and 100 Hz pulses that never restart on a selection change.
// - After a selection change the flag is set if the old pulse was low and the newly selected pulse is high.
// - The pulses start with fixed phase offsets that are each shorter than any period.
// - After power-on the flag stays zero and only a backup reset can set it until software has read it once.
// - A flag read returns the current value and, unless a set arrives with it, clears the flag in the same access.
// - After CE goes high the backup reset fires on the next selected rising edge (in delayed mode, the first one once the carry count is reached), setting the flag.
// - The first read after reset shows zero after power-on and one after a backup reset.
// - Either reset restarts instruction fetch from address zero.
// - With CE low the pulses and flag keep running unless clock stop is in force.
// - With the delayed backup reset in use the elapsed interval count is kept readable.
// - A 2-bit select picks the interval, is cleared on power-on and watchdog reset, kept on backup.
// - A read that coincides with the firing edge wins and the backup reset waits one more edge.
`timescale 1ns/1ps
`default_nettype none
`include "ift_regs.svh"

module ift_timer
    import ift_pkg::*;
#(
    parameter int PERIOD_100MS = `IFT_INTERVAL_100MS_NS / `IFT_CLK_PERIOD_NS,
    parameter int PERIOD_50MS  = `IFT_INTERVAL_50MS_NS / `IFT_CLK_PERIOD_NS,
    parameter int PERIOD_20MS  = `IFT_INTERVAL_20MS_NS / `IFT_CLK_PERIOD_NS,
    parameter int PERIOD_10MS  = `IFT_INTERVAL_10MS_NS / `IFT_CLK_PERIOD_NS,
    parameter int PHASE_STEP   = `IFT_PHASE_STEP_NS / `IFT_CLK_PERIOD_NS
) (
    input  wire logic                   CLK,
    input  wire logic                   RESET_N,
    input  wire logic                   WDT_RESET,
    input  wire logic                   CE,
    input  wire logic                   CLK_STOP,
    input  wire ift_pkg::ift_sel_wr_t   SEL_WRITE,
    input  wire ift_pkg::ift_delay_cfg_t DELAY_CFG,
    input  wire logic                   FLAG_RD,
    output var  logic                   FLAG_RDATA,
    output var  ift_pkg::ift_sel_t      SEL_Q,
    output var  logic [`IFT_CARRY_W-1:0] CARRY_COUNT,
    output var  logic                   BACKUP_RESET,
    output var  logic                   FETCH_RESTART,
    output var  logic [`IFT_ADDR_W-1:0] FETCH_ADDR
);

    // ------------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------------

    // Every offset must stay below the shortest period so no phase reaches
    // past a whole interval.
    if (PHASE_STEP * (`IFT_NUM_PULSES - 1) >= PERIOD_10MS) begin : g_bad_phase
        $error("ift_timer: PHASE_STEP too large for PERIOD_10MS");
    end
    if (PERIOD_10MS > PERIOD_20MS || PERIOD_20MS > PERIOD_50MS ||
        PERIOD_50MS > PERIOD_100MS) begin : g_bad_order
        $error("ift_timer: interval periods must rise with the interval");
    end

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [`IFT_NUM_PULSES-1:0] pulses;
    logic                       rise;
    logic                       run;
    logic                       armed_reg;
    logic                       flag_reg;
    logic                       flag_next;
    logic                       ce_q_reg;
    logic                       ce_rise;
    logic                       fire_ok;
    logic                       backup_fire;
    logic                       por_pend_reg;
    ift_sel_t                   sel_reg;
    ift_state_t                 state_reg;
    logic [`IFT_CARRY_W-1:0]    carry_reg;

    // Period for each select code, indexed by the code itself.
    function automatic int period_of(input int idx);
        case (idx)
            0:       period_of = PERIOD_100MS;
            1:       period_of = PERIOD_50MS;
            2:       period_of = PERIOD_20MS;
            default: period_of = PERIOD_10MS;
        endcase
    endfunction

    // ------------------------------------------------------------------------
    // Interval pulses
    // ------------------------------------------------------------------------

    // Clock stop freezes the dividers; nothing else pauses them.
    assign run = ~CLK_STOP;

    // One divider per interval, each started at its own fixed offset.
    for (genvar i = 0; i < `IFT_NUM_PULSES; i++) begin : g_div
        ift_pulse_div #(
            .PERIOD (period_of(i)),
            .PHASE  (PHASE_STEP * i)
        ) u_div (
            .clk   (CLK),
            .rst_n (RESET_N),
            .run   (run),
            .pulse (pulses[i])
        );
    end

    ift_edge_sel u_edge (
        .clk    (CLK),
        .rst_n  (RESET_N),
        .pulses (pulses),
        .sel    (sel_reg),
        .rise   (rise)
    );

    // ------------------------------------------------------------------------
    // Interval selection
    // ------------------------------------------------------------------------

    // A backup reset leaves the selection alone so the watch keeps its pace.
    always_ff @(posedge CLK) begin
        if (!RESET_N || WDT_RESET) begin
            sel_reg <= ift_sel_t'(`IFT_SEL_RESET);
        end else if (SEL_WRITE.wr) begin
            sel_reg <= SEL_WRITE.data;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            SEL_Q <= ift_sel_t'(`IFT_SEL_RESET);
        end else begin
            SEL_Q <= sel_reg;
        end
    end

    // ------------------------------------------------------------------------
    // Backup reset sequencing
    // ------------------------------------------------------------------------

    // The previous CE sample starts high, so a CE pin already high at power-on
    // is not taken for a step up and cannot fire a backup reset by itself.
    assign ce_rise = CE & ~ce_q_reg;

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            ce_q_reg <= 1'b1;
        end else begin
            ce_q_reg <= CE;
        end
    end

    // Without the delay option the first edge may fire; with it, the carry
    // count must first reach the programmed number of intervals.
    assign fire_ok = ~DELAY_CFG.en || (carry_reg >= DELAY_CFG.count);

    // A read in the firing cycle wins; the reset then waits for another edge.
    assign backup_fire = (state_reg == IFT_ST_WAIT) && rise && fire_ok
                         && ~FLAG_RD;

    // Waits for CE to step up, then for the right pulse edge.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            state_reg <= IFT_ST_IDLE;
        end else begin
            case (state_reg)
                IFT_ST_IDLE: begin
                    if (ce_rise) begin
                        state_reg <= IFT_ST_WAIT;
                    end
                end
                IFT_ST_WAIT: begin
                    if (backup_fire) begin
                        state_reg <= IFT_ST_DONE;
                    end
                end
                IFT_ST_DONE: begin
                    state_reg <= IFT_ST_IDLE;
                end
                default: begin
                    state_reg <= IFT_ST_IDLE;
                end
            endcase
        end
    end

    // Counts selected edges seen while waiting short of the delay, not the firing edge; software reads the total.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            carry_reg <= `IFT_CARRY_RESET;
        end else if (state_reg == IFT_ST_IDLE && ce_rise) begin
            carry_reg <= `IFT_CARRY_RESET;
        end else if (state_reg == IFT_ST_WAIT && rise && !fire_ok) begin
            carry_reg <= carry_reg + `IFT_CARRY_ONE;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            CARRY_COUNT <= `IFT_CARRY_RESET;
        end else begin
            CARRY_COUNT <= carry_reg;
        end
    end

    // ------------------------------------------------------------------------
    // Interval flag
    // ------------------------------------------------------------------------

    // Setting by a pulse edge is held off after power-on until the first read or a backup reset, so that a
    // zero at the first read can only mean power-on.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            armed_reg <= 1'b0;
        end else if (FLAG_RD || backup_fire) begin
            armed_reg <= 1'b1;
        end
    end

    // A set arriving with a read wins over the clear, so no interval is lost.
    always_comb begin
        flag_next = flag_reg;
        if (backup_fire) begin
            flag_next = 1'b1;
        end else if (rise && armed_reg) begin
            flag_next = 1'b1;
        end else if (FLAG_RD) begin
            flag_next = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // Read data shows the flag as it stood before the clearing edge.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            FLAG_RDATA <= 1'b0;
        end else if (FLAG_RD) begin
            FLAG_RDATA <= flag_reg;
        end
    end

    // ------------------------------------------------------------------------
    // Fetch restart
    // ------------------------------------------------------------------------

    // Power-on restart is one pulse on the first edge after release.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            por_pend_reg <= 1'b1;
        end else begin
            por_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            BACKUP_RESET  <= 1'b0;
            FETCH_RESTART <= 1'b0;
        end else begin
            BACKUP_RESET  <= backup_fire;
            FETCH_RESTART <= backup_fire | por_pend_reg;
        end
    end

    // The vector is fixed; it is a register only so the port is a flop.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            FETCH_ADDR <= `IFT_RESET_VECTOR;
        end else begin
            FETCH_ADDR <= `IFT_RESET_VECTOR;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    chk_unarmed_no_set: assert property (
        (!armed_reg && !backup_fire && !flag_reg) |=> !flag_reg)
        else $error("flag set before first read");
    chk_read_clears: assert property (
        (FLAG_RD && !rise && !backup_fire) |=> (!flag_reg && FLAG_RDATA == $past(flag_reg)))
        else $error("read did not return and clear the flag");
    chk_rise_sets: assert property (
        (rise && armed_reg) |=> flag_reg)
        else $error("armed rising edge did not set flag");
    chk_no_edge_hold: assert property (
        (!rise && !FLAG_RD && !backup_fire) |=> flag_reg == $past(flag_reg))
        else $error("flag changed without edge or read");
    chk_read_defers: assert property (
        (state_reg == IFT_ST_WAIT && rise && FLAG_RD) |=> (!BACKUP_RESET && state_reg == IFT_ST_WAIT))
        else $error("backup reset not deferred by read");
    chk_backup_on_edge: assert property (
        BACKUP_RESET |-> ($past(rise) && flag_reg && FETCH_RESTART))
        else $error("backup reset off edge or without flag");
    // The pulse register may still step on the first stopped edge, and a
    // selection change may still make one switch edge, so both are left out.
    chk_stop_freezes: assert property (
        (CLK_STOP [*3] ##0 (!$past(SEL_WRITE.wr) && !$past(WDT_RESET))) |-> !rise)
        else $error("edge seen during clock stop");
    chk_sel_wdt_clear: assert property (
        WDT_RESET |=> sel_reg == ift_sel_t'(`IFT_SEL_RESET))
        else $error("watchdog reset did not clear select");
    chk_carry_counts: assert property (
        (state_reg == IFT_ST_WAIT && rise && !fire_ok) |=> carry_reg == $past(carry_reg) + `IFT_CARRY_ONE)
        else $error("carry count did not advance");
    chk_fetch_vector: assert property (
        FETCH_RESTART |-> FETCH_ADDR == `IFT_RESET_VECTOR)
        else $error("restart not at address zero");

    cov_backup_fire: cover property (ce_rise ##[1:1000] BACKUP_RESET);
    cov_read_collide: cover property (state_reg == IFT_ST_WAIT && rise && FLAG_RD);
    cov_sel_switch_set: cover property (SEL_WRITE.wr ##1 rise);
    cov_first_read: cover property (!armed_reg && FLAG_RD);

endmodule : ift_timer

`default_nettype wire

// ==== bench/test_ift_timer.sv ====
// Self-checking bench for the interval flag timer with backup reset.
// Assumes the core package and timer are compiled first; the dividers are shortened.
`timescale 1ns/1ps
`default_nettype none

module test_ift_timer;
    import ift_pkg::*;

    // ------------------------------------------------------------------------
    // Shortened periods, so that every interval fits in a short run
    // ------------------------------------------------------------------------
    localparam int P100  = 400;
    localparam int P50   = 200;
    localparam int P20   = 80;
    localparam int P10   = 40;
    localparam int PSTEP = 4;

    typedef struct packed {
        ift_sel_t    sel;
        logic [15:0] period;
    } ift_tb_row_t;

    logic                CLK;
    logic                RESET_N;
    logic                WDT_RESET;
    logic                CE;
    logic                CLK_STOP;
    ift_sel_wr_t         SEL_WRITE;
    ift_delay_cfg_t      DELAY_CFG;
    logic                FLAG_RD;
    logic                FLAG_RDATA;
    ift_sel_t            SEL_Q;
    logic [3:0]          CARRY_COUNT;
    logic                BACKUP_RESET;
    logic                FETCH_RESTART;
    logic [13:0]         FETCH_ADDR;
    int                  n_mismatch;
    int                  checks;
    int                  cyc_n;
    int                  n_ones;
    int                  t1;
    int                  t2;
    int                  n_bup;
    int                  t_bup;
    logic                last_rd;
    ift_tb_row_t         rows [4];

    ift_timer #(
        .PERIOD_100MS (P100),
        .PERIOD_50MS  (P50),
        .PERIOD_20MS  (P20),
        .PERIOD_10MS  (P10),
        .PHASE_STEP   (PSTEP)
    ) dut (
        .CLK           (CLK),
        .RESET_N       (RESET_N),
        .WDT_RESET     (WDT_RESET),
        .CE            (CE),
        .CLK_STOP      (CLK_STOP),
        .SEL_WRITE     (SEL_WRITE),
        .DELAY_CFG     (DELAY_CFG),
        .FLAG_RD       (FLAG_RD),
        .FLAG_RDATA    (FLAG_RDATA),
        .SEL_Q         (SEL_Q),
        .CARRY_COUNT   (CARRY_COUNT),
        .BACKUP_RESET  (BACKUP_RESET),
        .FETCH_RESTART (FETCH_RESTART),
        .FETCH_ADDR    (FETCH_ADDR)
    );

    // ------------------------------------------------------------------------
    // Clock, comparisons and the closing task
    // ------------------------------------------------------------------------
    // The clock runs at 25 MHz.
    initial CLK = 1'b0;
    always #20 CLK = ~CLK;

    // Compares a design value bit for bit, so an unknown never matches.
    task automatic cmp_v(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Compares a cycle count measured by the bench.
    task automatic cmp_n(input int got, input int exp);
        checks++;
        if (got != exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Stepping and observation
    // ------------------------------------------------------------------------
    // Clears the event record kept by the stepping task.
    task automatic clr();
        n_ones = 0;
        t1     = 0;
        t2     = 0;
        n_bup  = 0;
        t_bup  = 0;
    endtask

    // Steps n cycles with the read strobe at rd; only a taken read counts as a sample,
    // because the read data holds its old value between reads.
    task automatic run(input int n, input logic rd, input logic stop);
        logic taken;
        for (int i = 0; i < n; i++) begin
            @(posedge CLK);
            taken = FLAG_RD;
            FLAG_RD <= rd;
            #1;
            cyc_n++;
            if (taken === 1'b1) begin
                last_rd = FLAG_RDATA;
                if (FLAG_RDATA === 1'b1) begin
                    n_ones++;
                    if (n_ones == 1) t1 = cyc_n;
                    if (n_ones == 2) t2 = cyc_n;
                end
            end
            if (BACKUP_RESET === 1'b1) begin
                n_bup++;
                t_bup = cyc_n;
                cmp_v(16'(FETCH_RESTART), 16'h0001);
                cmp_v(16'(FETCH_ADDR), 16'h0000);
                if (stop) break;
            end
        end
    endtask

    // One read of the flag; its value lands in last_rd.
    task automatic read_once();
        run(1, 1'b1, 1'b0);
        run(1, 1'b0, 1'b0);
    endtask

    // Writes the interval select for one cycle and waits until it shows.
    task automatic sel_write(input ift_sel_t s);
        @(posedge CLK);
        SEL_WRITE <= '{wr: 1'b1, data: s};
        @(posedge CLK);
        SEL_WRITE <= '{wr: 1'b0, data: s};
        run(2, 1'b0, 1'b0);
    endtask

    // ------------------------------------------------------------------------
    // Watchdog: the whole sequence needs well under ten thousand cycles
    // ------------------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge CLK);
        n_mismatch++;
        $display("Watchdog expired at t=%0t", $time);
        test_done();
    end

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        RESET_N    = 1'b0;
        WDT_RESET  = 1'b0;
        CE         = 1'b0;
        CLK_STOP   = 1'b0;
        SEL_WRITE  = '0;
        DELAY_CFG  = '0;
        FLAG_RD    = 1'b0;
        n_mismatch = 0;
        checks     = 0;
        cyc_n      = 0;
        last_rd    = 1'b0;
        clr();
        rows[0] = '{IFT_SEL_10MS, 16'h0028};
        rows[1] = '{IFT_SEL_20MS, 16'h0050};
        rows[2] = '{IFT_SEL_50MS, 16'h00C8};
        rows[3] = '{IFT_SEL_100MS, 16'h0190};

        // Reset holds every output low; the first edge after release restarts fetch.
        repeat (20) @(posedge CLK);
        #1;
        cmp_v({BACKUP_RESET, FETCH_RESTART, 14'(SEL_Q)}, 16'h0000);
        cmp_v(16'(FETCH_ADDR), 16'h0000);
        @(posedge CLK);
        RESET_N <= 1'b1;
        run(1, 1'b0, 1'b0);
        cmp_v(16'(FETCH_RESTART), 16'h0001);
        run(1, 1'b0, 1'b0);
        cmp_v(16'(FETCH_RESTART), 16'h0000);

        // Unread since power-on, the flag never sets; once read it sets and clears on read.
        run(2 * P100 + 20, 1'b0, 1'b0);
        read_once();
        cmp_v(16'(last_rd), 16'h0000);
        run(P100 + 20, 1'b0, 1'b0);
        read_once();
        cmp_v(16'(last_rd), 16'h0001);
        read_once();
        cmp_v(16'(last_rd), 16'h0000);

        // Each select code: select shows, and reads every cycle see one set per period.
        foreach (rows[i]) begin
            sel_write(rows[i].sel);
            cmp_v(16'(SEL_Q), 16'(rows[i].sel));
            read_once();
            clr();
            run(2 * int'(rows[i].period) + 10, 1'b1, 1'b0);
            cmp_n(t2 - t1, int'(rows[i].period));
        end

        // Clock stop freezes the pulses, so no set arrives; release resumes them.
        @(posedge CLK);
        CLK_STOP <= 1'b1;
        read_once();
        clr();
        run(2 * P100, 1'b1, 1'b0);
        cmp_n(n_ones, 0);
        @(posedge CLK);
        CLK_STOP <= 1'b0;
        run(P100 + 10, 1'b1, 1'b0);
        cmp_v(16'(n_ones > 0), 16'h0001);

        // Watchdog reset clears the select.
        sel_write(IFT_SEL_10MS);
        @(posedge CLK);
        WDT_RESET <= 1'b1;
        @(posedge CLK);
        WDT_RESET <= 1'b0;
        run(2, 1'b0, 1'b0);
        cmp_v(16'(SEL_Q), 16'(IFT_SEL_100MS));

        // A read on every firing edge keeps deferring the backup reset.
        sel_write(IFT_SEL_20MS);
        @(posedge CLK);
        CE <= 1'b1;
        clr();
        run(3 * P20, 1'b1, 1'b0);
        cmp_n(n_bup, 0);

        // Once reads stop it fires on the next rise, sets the flag and keeps the select.
        clr();
        run(P20 + 10, 1'b0, 1'b1);
        cmp_n(n_bup, 1);
        read_once();
        cmp_v(16'(last_rd), 16'h0001);
        cmp_v(16'(SEL_Q), 16'(IFT_SEL_20MS));
        @(posedge CLK);
        CE <= 1'b0;
        run(4, 1'b0, 1'b0);

        // Delayed mode: two rises are counted before the third one fires.
        @(posedge CLK);
        DELAY_CFG <= '{en: 1'b1, count: 4'h2};
        CE        <= 1'b1;
        clr();
        t1 = cyc_n;
        run(3 * P20 + 20, 1'b0, 1'b1);
        cmp_n(n_bup, 1);
        cmp_v(16'((t_bup - t1) > 2 * P20), 16'h0001);
        run(2, 1'b0, 1'b0);
        cmp_v(16'(CARRY_COUNT), 16'h0002);
        @(posedge CLK);
        CE <= 1'b0;
        run(4, 1'b0, 1'b0);

        test_done();
    end

endmodule // test_ift_timer

`default_nettype wire
